/* logic/i2sw_if.sv */
`timescale 1ns/1ps
interface i2sw_if;
	// Open-drain drives of the controller end.
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	// Open-drain drives of the switch end.
	logic scl_d_o;
	logic scl_d_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic irq_o;
	logic irq_oe;
	// Push-pull reset pin driven by the controller end.
	logic rst_n;
	// Resolved wire levels, pulled up when nobody drives.
	logic scl;
	logic sda;
	logic irq_n;

	assign scl   = (~scl_h_oe | scl_h_o) & (~scl_d_oe | scl_d_o);
	assign sda   = (~sda_h_oe | sda_h_o) & (~sda_d_oe | sda_d_o);
	assign irq_n = ~irq_oe | irq_o;

	modport dev (
		input  scl, sda, rst_n,
		output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, irq_o, irq_oe
	);
	modport host (
		input  scl, sda, irq_n,
		output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, rst_n
	);
endinterface

/* logic/i2sw_master.sv */
`timescale 1ns/1ps
module i2sw_master import i2sw_pkg::*; #(
	parameter int HALF_CYC = SCL_HALF_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       srst,
	// Upstream link
	i2sw_if.host            up,
	// Command
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_rw,
	input  wire logic [6:0] cmd_addr,
	input  wire logic [7:0] cmd_wdata,
	// Response
	output logic            rsp_valid,
	output logic [7:0]      rsp_rdata,
	output logic            rsp_nack,
	// Switch reset and interrupt
	input  wire logic       hold_reset,
	output logic            irq_n
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		H_IDLE  = 6'h01,
		H_START = 6'h02,
		H_LOW   = 6'h04,
		H_HIGH  = 6'h08,
		H_STOP1 = 6'h10,
		H_STOP2 = 6'h20
	} i2sw_hstate_t;

	i2sw_hstate_t st_reg;
	logic [15:0]  tmr_reg;
	logic [4:0]   bit_reg;
	logic [8:0]   sh_reg;
	logic [8:0]   second_reg;
	logic         rw_reg;
	logic         scl_oe_reg;
	logic         sda_oe_reg;
	logic         rst_n_reg;
	logic [7:0]   rdata_reg;
	logic         nack_reg;
	logic         rsp_reg;
	logic [1:0]   scl_sy;
	logic [1:0]   sda_sy;
	logic [1:0]   irq_sy;
	logic         irq_reg;
	logic         tick;

	// ---------------------------------------------------------------
	// Synchronisers and reset pin
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		scl_sy <= {scl_sy[0], up.scl};
		sda_sy <= {sda_sy[0], up.sda};
		irq_sy <= {irq_sy[0], up.irq_n};
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rst_n_reg <= 1'b1;
			irq_reg   <= 1'b1;
		end else begin
			rst_n_reg <= ~hold_reset;
			irq_reg   <= irq_sy[1];
		end
	end

	// ---------------------------------------------------------------
	// Half-period timer
	// ---------------------------------------------------------------
	// The timer stalls in H_HIGH while a driven-high clock still reads low, so a
	// stretching target slows the frame rather than breaking it.
	assign tick = (tmr_reg == 16'(HALF_CYC - 1));

	always_ff @(posedge mclk) begin
		if (srst || st_reg == H_IDLE || tick) begin
			tmr_reg <= 16'h0000;
		end else if (!(st_reg == H_HIGH && !scl_sy[1])) begin
			tmr_reg <= tmr_reg + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		rsp_reg <= 1'b0;
		if (srst) begin
			st_reg     <= H_IDLE;
			bit_reg    <= 5'h00;
			sh_reg     <= 9'h1FF;
			second_reg <= 9'h1FF;
			rw_reg     <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			rdata_reg  <= 8'h00;
			nack_reg   <= 1'b0;
			rsp_reg    <= 1'b0;
		end else begin
			unique case (st_reg)
			H_IDLE: begin
				if (cmd_valid) begin
					sh_reg     <= {cmd_addr, cmd_rw, 1'b1};
					second_reg <= cmd_rw ? 9'h1FF : {cmd_wdata, 1'b1};
					rw_reg     <= cmd_rw;
					bit_reg    <= 5'h00;
					nack_reg   <= 1'b0;
					sda_oe_reg <= 1'b1;
					st_reg     <= H_START;
				end
			end
			H_START: begin
				if (tick) begin
					scl_oe_reg <= 1'b1;
					sda_oe_reg <= ~sh_reg[8];
					st_reg     <= H_LOW;
				end
			end
			H_LOW: begin
				if (tick) begin
					scl_oe_reg <= 1'b0;
					st_reg     <= H_HIGH;
				end
			end
			H_HIGH: begin
				if (tick) begin
					scl_oe_reg <= 1'b1;
					bit_reg    <= bit_reg + 5'h01;
					if (rw_reg && bit_reg > ADDR_ACK_BIT &&
						bit_reg < LAST_BIT) begin
						rdata_reg <= {rdata_reg[6:0], sda_sy[1]};
					end
					if ((bit_reg == ADDR_ACK_BIT ||
						(bit_reg == LAST_BIT && !rw_reg)) && sda_sy[1]) begin
						nack_reg   <= 1'b1;
						sda_oe_reg <= 1'b1;
						st_reg     <= H_STOP1;
					end else if (bit_reg == LAST_BIT) begin
						sda_oe_reg <= 1'b1;
						st_reg     <= H_STOP1;
					end else if (bit_reg == ADDR_ACK_BIT) begin
						sh_reg     <= second_reg;
						sda_oe_reg <= ~second_reg[8];
						st_reg     <= H_LOW;
					end else begin
						sh_reg     <= {sh_reg[7:0], 1'b1};
						sda_oe_reg <= ~sh_reg[7];
						st_reg     <= H_LOW;
					end
				end
			end
			H_STOP1: begin
				if (tick) begin
					scl_oe_reg <= 1'b0;
					st_reg     <= H_STOP2;
				end
			end
			H_STOP2: begin
				if (tick) begin
					sda_oe_reg <= 1'b0;
					rsp_reg    <= 1'b1;
					st_reg     <= H_IDLE;
				end
			end
			default: begin
				st_reg <= H_IDLE;
			end
			endcase
		end
	end

	assign cmd_ready   = (st_reg == H_IDLE);
	assign rsp_valid   = rsp_reg;
	assign rsp_rdata   = rdata_reg;
	assign rsp_nack    = nack_reg;
	assign irq_n       = irq_reg;
	assign up.scl_h_o  = 1'b0;
	assign up.scl_h_oe = scl_oe_reg;
	assign up.sda_h_o  = 1'b0;
	assign up.sda_h_oe = sda_oe_reg;
	assign up.rst_n    = rst_n_reg;

endmodule // i2sw_master

/* logic/i2sw_pkg.sv */
package i2sw_pkg;
	// ---------------------------------------------------------------
	// Channels and straps
	// ---------------------------------------------------------------
	localparam int         NUM_CH      = 4;
	localparam logic [4:0] ADDR_HI_DEF = 5'h10;
	localparam logic [3:0] CTRL_RESET  = 4'h0;
	localparam logic [3:0] BYTE_BITS   = 4'h8;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ     = 10000;
	localparam int SCL_MAX_KHZ = 400;
	// Least half period of the serial clock, rounded up to whole cycles.
	localparam int SCL_HALF_CYC =
		(CLK_KHZ + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);

	// ---------------------------------------------------------------
	// Frame layout seen by the controller
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_ACK_BIT = 5'h08;
	localparam logic [4:0] LAST_BIT     = 5'h11;
endpackage

/* logic/i2sw_switch.sv */
`timescale 1ns/1ps
module i2sw_switch import i2sw_pkg::*; #(
	parameter logic [4:0] ADDR_HI = ADDR_HI_DEF,
	parameter int         NCH     = NUM_CH
) (
	// Clock and power-on reset
	input  wire logic           mclk,
	input  wire logic           srst,
	// Upstream link
	i2sw_if.dev                 up,
	// Address straps
	input  wire logic           addr_strap_bit0,
	input  wire logic           addr_strap_bit1,
	// Downstream clock lines
	input  wire logic [NCH-1:0] downstream_clock_line_in,
	output logic      [NCH-1:0] downstream_clock_line_out,
	output logic      [NCH-1:0] downstream_clock_line_oe,
	// Downstream data lines
	input  wire logic [NCH-1:0] downstream_data_line_in,
	output logic      [NCH-1:0] downstream_data_line_out,
	output logic      [NCH-1:0] downstream_data_line_oe,
	// Downstream interrupts
	input  wire logic [NCH-1:0] downstream_irq_in
);

	// ---------------------------------------------------------------
	// Types and state
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		T_IDLE  = 5'h01,
		T_RX    = 5'h02,
		T_ACK   = 5'h04,
		T_TX    = 5'h08,
		T_TXACK = 5'h10
	} i2sw_tstate_t;

	i2sw_tstate_t     st_reg;
	logic [3:0]       cnt_reg;
	logic [7:0]       sh_reg, tx_reg, rd_byte;
	logic             is_addr_reg, rd_reg, mack_reg, tsda_oe_reg, irq_n_reg;
	logic [NCH-1:0]   en_reg;
	logic [1:0]       strap_reg;
	logic             up_scl_oe_reg, up_sda_oe_reg;
	logic [2:0]       scl_hist_reg, sda_hist_reg;
	logic [NCH-1:0]   ds_scl_oe_reg, ds_sda_oe_reg;

	logic [1:0]       up_scl_sy, up_sda_sy, rst_n_sy, strap0_sy, strap1_sy;
	logic [NCH-1:0]   irq_s1, irq_s2, ds_scl_s1, ds_scl_s2;
	logic [NCH-1:0]   ds_sda_s1, ds_sda_s2;
	logic             clr, scl_s, sda_s, scl_p, sda_p;
	logic             scl_rise, scl_fall, start_c, stop_c;
	logic [6:0]       my_addr;

	// ---------------------------------------------------------------
	// Pass-gate helpers
	// ---------------------------------------------------------------
	// A channel line is pulled low when it is enabled, the upstream
	// line is low and that low is not our own echo.
	function automatic logic [NCH-1:0] route_down(
		input logic [NCH-1:0] en,
		input logic           up_lvl,
		input logic [2:0]     own
	);
		route_down = en & {NCH{~up_lvl & ~(|own)}};
	endfunction

	function automatic logic route_up(
		input logic [NCH-1:0] en,
		input logic [NCH-1:0] ds_lvl
	);
		route_up = |(en & ~ds_lvl);
	endfunction

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		up_scl_sy <= {up_scl_sy[0], up.scl};
		up_sda_sy <= {up_sda_sy[0], up.sda};
		rst_n_sy  <= {rst_n_sy[0], up.rst_n};
		strap0_sy <= {strap0_sy[0], addr_strap_bit0};
		strap1_sy <= {strap1_sy[0], addr_strap_bit1};
		irq_s1    <= downstream_irq_in;
		irq_s2    <= irq_s1;
		ds_scl_s1 <= downstream_clock_line_in;
		ds_scl_s2 <= ds_scl_s1;
		ds_sda_s1 <= downstream_data_line_in;
		ds_sda_s2 <= ds_sda_s1;
		scl_p     <= up_scl_sy[1];
		sda_p     <= up_sda_sy[1];
	end

	assign scl_s    = up_scl_sy[1];
	assign sda_s    = up_sda_sy[1];
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
	assign clr      = srst | ~rst_n_sy[1];

	// ---------------------------------------------------------------
	// Address straps
	// ---------------------------------------------------------------
	// The straps are static, so sampling them while reset is held keeps
	// the address stable through a whole frame.
	always_ff @(posedge mclk) begin
		if (clr) begin
			strap_reg <= {strap1_sy[1], strap0_sy[1]};
		end
	end

	assign my_addr = {ADDR_HI, strap_reg};

	// ---------------------------------------------------------------
	// Interrupt merge
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= &irq_s2;
		end
	end

	assign up.irq_o  = 1'b0;
	assign up.irq_oe = ~irq_n_reg;

	// ---------------------------------------------------------------
	// Serial target
	// ---------------------------------------------------------------
	assign rd_byte = 8'(en_reg);
	always_ff @(posedge mclk) begin
		if (clr) begin
			st_reg      <= T_IDLE;
			cnt_reg     <= 4'h0;
			sh_reg      <= 8'h00;
			tx_reg      <= 8'h00;
			is_addr_reg <= 1'b0;
			rd_reg      <= 1'b0;
			mack_reg    <= 1'b0;
			tsda_oe_reg <= 1'b0;
			en_reg      <= NCH'(CTRL_RESET);
		end else if (start_c) begin
			st_reg      <= T_RX;
			cnt_reg     <= 4'h0;
			is_addr_reg <= 1'b1;
			tsda_oe_reg <= 1'b0;
		end else if (stop_c) begin
			st_reg      <= T_IDLE;
			tsda_oe_reg <= 1'b0;
		end else begin
			unique case (st_reg)
			T_IDLE: begin
				tsda_oe_reg <= 1'b0;
			end
			T_RX: begin
				if (scl_rise) begin
					sh_reg  <= {sh_reg[6:0], sda_s};
					cnt_reg <= cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == BYTE_BITS) begin
					if (!is_addr_reg) begin
						en_reg      <= sh_reg[NCH-1:0];
						tsda_oe_reg <= 1'b1;
						st_reg      <= T_ACK;
					end else if (sh_reg[7:1] == my_addr) begin
						rd_reg      <= sh_reg[0];
						tsda_oe_reg <= 1'b1;
						st_reg      <= T_ACK;
					end else begin
						st_reg <= T_IDLE;
					end
				end
			end
			T_ACK: begin
				if (scl_fall) begin
					cnt_reg     <= 4'h0;
					is_addr_reg <= 1'b0;
					if (rd_reg) begin
						tx_reg      <= rd_byte;
						tsda_oe_reg <= ~rd_byte[7];
						st_reg      <= T_TX;
					end else begin
						tsda_oe_reg <= 1'b0;
						st_reg      <= T_RX;
					end
				end
			end
			T_TX: begin
				if (scl_rise) begin
					cnt_reg <= cnt_reg + 4'h1;
				end else if (scl_fall) begin
					if (cnt_reg == BYTE_BITS) begin
						tsda_oe_reg <= 1'b0;
						st_reg      <= T_TXACK;
					end else begin
						tsda_oe_reg <= ~tx_reg[6];
						tx_reg      <= {tx_reg[6:0], 1'b0};
					end
				end
			end
			T_TXACK: begin
				if (scl_rise) begin
					mack_reg <= ~sda_s;
				end else if (scl_fall) begin
					cnt_reg <= 4'h0;
					if (mack_reg) begin
						tx_reg      <= rd_byte;
						tsda_oe_reg <= ~rd_byte[7];
						st_reg      <= T_TX;
					end else begin
						st_reg <= T_IDLE;
					end
				end
			end
			default: begin
				st_reg <= T_IDLE;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Channel pass gates
	// ---------------------------------------------------------------
	// Each direction is resynchronised, so a low crosses the switch with
	// a few cycles of delay; the history of our own upstream drive masks
	// the echo that would otherwise latch both sides low.
	always_ff @(posedge mclk) begin
		if (clr) begin
			up_scl_oe_reg <= 1'b0;
			up_sda_oe_reg <= 1'b0;
			scl_hist_reg  <= 3'h0;
			sda_hist_reg  <= 3'h0;
			ds_scl_oe_reg <= '0;
			ds_sda_oe_reg <= '0;
		end else begin
			up_scl_oe_reg <= route_up(en_reg, ds_scl_s2);
			up_sda_oe_reg <= route_up(en_reg, ds_sda_s2);
			scl_hist_reg  <= {scl_hist_reg[1:0], up_scl_oe_reg};
			sda_hist_reg  <= {sda_hist_reg[1:0], up_sda_oe_reg};
			ds_scl_oe_reg <= route_down(en_reg, scl_s,
				{scl_hist_reg[1:0], up_scl_oe_reg});
			ds_sda_oe_reg <= route_down(en_reg, sda_s,
				{sda_hist_reg[1:0], up_sda_oe_reg});
		end
	end

	assign up.scl_d_o   = 1'b0;
	assign up.scl_d_oe  = up_scl_oe_reg;
	assign up.sda_d_o   = 1'b0;
	assign up.sda_d_oe  = up_sda_oe_reg | tsda_oe_reg;

	assign downstream_clock_line_out = '0;
	assign downstream_clock_line_oe  = ds_scl_oe_reg;
	assign downstream_data_line_out  = '0;
	assign downstream_data_line_oe   = ds_sda_oe_reg;

endmodule // i2sw_switch

/* sim/i2sw_checker.sv */
`timescale 1ns/1ps
module i2sw_checker import i2sw_pkg::*; (
	// Clock and power-on reset
	input wire logic       mclk,
	input wire logic       srst,
	// Resolved wires and reset pin
	input wire logic       scl,
	input wire logic       irq_n,
	input wire logic       rst_n,
	// Open-drain enables
	input wire logic       scl_h_oe,
	input wire logic       scl_d_oe,
	input wire logic       sda_d_oe,
	input wire logic       irq_oe,
	// Downstream interrupt levels
	input wire logic [3:0] downstream_irq_in
);
	default clocking cb @(posedge mclk);
	endclocking

	// ---------------------------------------------------------------
	// Sequences
	// ---------------------------------------------------------------
	sequence s_ack_start;
		$rose(sda_d_oe);
	endsequence
	sequence s_scl_low_phase;
		scl_h_oe [*8];
	endsequence
	sequence s_scl_high_phase;
		(!scl_h_oe) [*8];
	endsequence

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	// The input sync chain is two flops deep plus the merge register, so allow up to four edges.
	property p_irq_assert;
		disable iff (srst) $fell(&downstream_irq_in) |-> ##[2:4] !irq_n;
	endproperty
	property p_irq_release;
		disable iff (srst) $rose(&downstream_irq_in) |-> ##[2:4] irq_n;
	endproperty
	property p_irq_level;
		disable iff (srst)
		$stable(downstream_irq_in) [*5] |-> irq_n == &downstream_irq_in;
	endproperty
	property p_pin_reset;
		disable iff (srst) (!rst_n) [*6] |-> !scl_d_oe && !sda_d_oe;
	endproperty
	// No disable here: this one watches the reset itself.
	property p_por_quiet;
		srst [*2] |-> !scl_d_oe && !sda_d_oe && !irq_oe;
	endproperty
	property p_ack_low;
		disable iff (srst) s_ack_start |-> !scl;
	endproperty
	property p_ack_hold;
		disable iff (srst) s_ack_start |-> sda_d_oe [*8];
	endproperty
	property p_scl_low_min;
		disable iff (srst) $rose(scl_h_oe) |-> s_scl_low_phase;
	endproperty
	property p_scl_high_min;
		disable iff (srst) $fell(scl_h_oe) |-> s_scl_high_phase;
	endproperty

	a_irq_assert: assert property (p_irq_assert)
		else $error("interrupt output missed a low input");
	a_irq_release: assert property (p_irq_release)
		else $error("interrupt output stuck low");
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output differs from input levels");
	a_pin_reset: assert property (p_pin_reset)
		else $error("switch drives upstream while reset pin low");
	a_por_quiet: assert property (p_por_quiet)
		else $error("switch drives during power-on reset");
	a_ack_low: assert property (p_ack_low)
		else $error("switch pulled data low while clock high");
	a_ack_hold: assert property (p_ack_hold)
		else $error("switch data drive too short");
	a_scl_low_min: assert property (p_scl_low_min)
		else $error("clock low phase too short");
	a_scl_high_min: assert property (p_scl_high_min)
		else $error("clock high phase too short");
endmodule // i2sw_checker

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define check_eq(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
		end \
	end
module tb_top import i2sw_pkg::*;;
	localparam int LIMIT = 60000;
	// Bench bookkeeping
	logic       mclk;
	logic       srst;
	int         fail_count;
	int         compares;
	int         cycles = 0;
	logic [6:0] own_addr;
	logic [7:0] seen_oe;
	logic       seen_clr;
	// Master user side
	logic       cmd_valid;
	logic       cmd_ready;
	logic       cmd_rw;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic       rsp_valid;
	logic [7:0] rsp_rdata;
	logic       rsp_nack;
	logic       hold_reset;
	logic       irq_n;
	// Switch far side
	logic       addr_strap_bit0;
	logic       addr_strap_bit1;
	logic [3:0] downstream_clock_line_in;
	logic [3:0] downstream_data_line_in;
	logic [3:0] downstream_clock_line_oe;
	logic [3:0] downstream_data_line_oe;
	logic [3:0] downstream_irq_in;

	i2sw_if i2sw_if_inst ();
	i2sw_switch i2sw_switch_inst (.mclk, .srst, .up(i2sw_if_inst),
		.addr_strap_bit0, .addr_strap_bit1, .downstream_clock_line_in,
		.downstream_clock_line_out(), .downstream_clock_line_oe,
		.downstream_data_line_in, .downstream_data_line_out(),
		.downstream_data_line_oe, .downstream_irq_in);
	i2sw_master i2sw_master_inst (.mclk, .srst, .up(i2sw_if_inst),
		.cmd_valid, .cmd_ready, .cmd_rw, .cmd_addr, .cmd_wdata,
		.rsp_valid, .rsp_rdata, .rsp_nack, .hold_reset, .irq_n);
	i2sw_checker i2sw_checker_inst (.mclk, .srst,
		.scl(i2sw_if_inst.scl), .irq_n(i2sw_if_inst.irq_n),
		.rst_n(i2sw_if_inst.rst_n), .scl_h_oe(i2sw_if_inst.scl_h_oe),
		.scl_d_oe(i2sw_if_inst.scl_d_oe), .sda_d_oe(i2sw_if_inst.sda_d_oe),
		.irq_oe(i2sw_if_inst.irq_oe), .downstream_irq_in);

	always #50 mclk = ~mclk;

	// Collects every downstream pull seen since the last frame was taken.
	always @(posedge mclk) begin
		if (seen_clr)
			seen_oe <= 8'h00;
		else
			seen_oe <= seen_oe | {downstream_data_line_oe,
				downstream_clock_line_oe};
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Idle gap first so the switch sees the previous stop before a start.
	task automatic frame(input logic rw, input logic [6:0] addr,
		input logic [7:0] wdata);
		int n;
		n = 0;
		repeat (20) @(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_rw    <= rw;
		cmd_addr  <= addr;
		cmd_wdata <= wdata;
		seen_clr  <= 1'b1;
		@(posedge mclk);
		while (cmd_ready !== 1'b1) @(posedge mclk);
		cmd_valid <= 1'b0;
		seen_clr  <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 3000);
		`check_eq(rsp_valid, 1'b1)
	endtask

	task automatic t_address();
		for (int s = 0; s < 4; s++) begin
			addr_strap_bit0 <= s[0];
			addr_strap_bit1 <= s[1];
			srst            <= 1'b1;
			repeat (5) @(posedge mclk);
			srst     <= 1'b0;
			own_addr = {ADDR_HI_DEF, s[1:0]};
			frame(1'b1, own_addr, 8'h00);
			`check_eq(rsp_nack, 1'b0)
			`check_eq(rsp_rdata, 8'h00)
			frame(1'b0, own_addr ^ 7'h01, 8'h03);
			`check_eq(rsp_nack, 1'b1)
			frame(1'b0, own_addr, {6'h3D, s[1:0]});
			`check_eq(rsp_nack, 1'b0)
			frame(1'b1, own_addr, 8'h00);
			`check_eq(rsp_rdata, {4'h0, 2'h1, s[1:0]})
		end
		$display("test address done");
	endtask

	task automatic t_channels();
		logic [3:0] pat [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hF, 4'h0};
		foreach (pat[i]) begin
			frame(1'b0, own_addr, {4'h0, pat[i]});
			frame(1'b1, own_addr, 8'h00);
			`check_eq(rsp_rdata, {4'h0, pat[i]})
			`check_eq(seen_oe, {pat[i], pat[i]})
		end
		$display("test channels done");
	endtask

	// A downstream device holding its clock low must reach upstream only
	// through an enabled channel.
	task automatic t_pass();
		frame(1'b0, own_addr, 8'h04);
		repeat (20) @(posedge mclk);
		downstream_clock_line_in <= 4'hB;
		repeat (10) @(posedge mclk);
		`check_eq(i2sw_if_inst.scl, 1'b0)
		downstream_clock_line_in <= 4'hD;
		repeat (10) @(posedge mclk);
		`check_eq(i2sw_if_inst.scl, 1'b1)
		downstream_clock_line_in <= 4'hF;
		frame(1'b1, own_addr, 8'h00);
		`check_eq(rsp_rdata, 8'h04)
		$display("test pass done");
	endtask

	task automatic t_irq();
		logic [3:0] pat [7] = '{4'hE, 4'hF, 4'hD, 4'hB, 4'h7, 4'h5, 4'hF};
		foreach (pat[i]) begin
			downstream_irq_in <= pat[i];
			repeat (10) @(posedge mclk);
			`check_eq(i2sw_if_inst.irq_n, &pat[i])
			`check_eq(irq_n, &pat[i])
		end
		$display("test irq done");
	endtask

	// Channel 0 is stuck low through the switch; the reset pin must free
	// the upstream clock by deselecting every channel.
	task automatic t_pin_reset();
		frame(1'b0, own_addr, 8'h0F);
		downstream_clock_line_in <= 4'hE;
		repeat (10) @(posedge mclk);
		`check_eq(i2sw_if_inst.scl, 1'b0)
		hold_reset <= 1'b1;
		repeat (8) @(posedge mclk);
		`check_eq(i2sw_if_inst.rst_n, 1'b0)
		`check_eq(i2sw_if_inst.scl, 1'b1)
		hold_reset               <= 1'b0;
		downstream_clock_line_in <= 4'hF;
		frame(1'b1, own_addr, 8'h00);
		`check_eq(rsp_rdata, 8'h00)
		$display("test pin_reset done");
	endtask

	initial begin
		mclk                     = 1'b0;
		srst                     = 1'b1;
		fail_count               = 0;
		compares                 = 0;
		seen_clr                 = 1'b1;
		cmd_valid                = 1'b0;
		cmd_rw                   = 1'b0;
		cmd_addr                 = 7'h00;
		cmd_wdata                = 8'h00;
		hold_reset               = 1'b0;
		addr_strap_bit0          = 1'b0;
		addr_strap_bit1          = 1'b0;
		downstream_clock_line_in = 4'hF;
		downstream_data_line_in  = 4'hF;
		downstream_irq_in        = 4'hF;
		repeat (5) @(posedge mclk);
		t_address();
		t_channels();
		t_pass();
		t_irq();
		t_pin_reset();
		report_and_stop();
	end
endmodule // tb_top
